// ===== rtl/wfad_pkg.sv
// shared constants for the word format and address decode block
package wfad_pkg;
	localparam int WORD_W = 24;
	localparam int ADDR_W = 15;
	localparam int OP_W = 7;
	localparam int CHAR_W = 6;
	// big-endian bit numbers: machine bit n sits at vector index 23-n
	localparam int BIT_IND = 23;
	localparam int BIT_IDX = 22;
	localparam int BIT_NOIDX = 21;
	localparam int OP_HI = 21;
	localparam int OP_LO = 15;
	localparam int SIGN_BIT = 23;
	// char size codes: 0=6,1=12,2=18,3=24 bits
	localparam logic [1:0] CSZ_6 = 2'h0;
	localparam logic [1:0] CSZ_24 = 2'h3;
	localparam logic [2:0] NUM_IO_BUF = 3'h2;
	localparam int BASE_IRQ = 2;
	localparam int IRQ_GROUP = 8;
	localparam int ADD_CYCLES = 2;
	// axi register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_INSTR = 8'h08;
	localparam logic [7:0] A_INDEX = 8'h0c;
	localparam logic [7:0] A_NEXTPTR = 8'h10;
	localparam logic [7:0] A_EFFADDR = 8'h14;
	localparam logic [7:0] A_MAINREG = 8'h18;
	localparam logic [7:0] A_EXTREG = 8'h1c;
	localparam logic [7:0] A_MEMBUF = 8'h20;
	localparam logic [7:0] A_CYCLES = 8'h24;
	localparam logic [7:0] A_IOCFG = 8'h28;
	localparam logic [7:0] A_IOWORD = 8'h2c;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// ===== rtl/wfad_char_asm.sv
// character buffer: assembles characters into 24-bit words
`timescale 1ns/1ps
module wfad_char_asm #(
	parameter int W = 24,
	parameter int C = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// character side
	input wire logic charValid,
	input wire logic [W-1:0] charData,
	input wire logic [1:0] charSize,
	// word side
	output logic wordValid,
	output logic [W-1:0] wordData
);
	logic [W-1:0] shift_q;
	logic [2:0] fill_q;
	logic [2:0] need;
	assign need = 3'(W / C) >> charSize; // 4,2,1(18->1 with remainder),0
	// characters shift in from the right, the word leaves when full, or after each character at 18 bits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= '0;
			fill_q <= '0;
			wordValid <= 1'b0;
			wordData <= '0;
		end else begin
			wordValid <= 1'b0;
			if (charValid) begin
				if (charSize == wfad_pkg::CSZ_24 || fill_q + 3'h1 >= need) begin
					wordValid <= 1'b1;
					wordData <= (charSize == wfad_pkg::CSZ_24) ? charData :
						W'((shift_q << (C * (32'(charSize) + 1))) | charData);
					fill_q <= '0;
					shift_q <= '0;
				end else begin
					shift_q <= W'((shift_q << (C * (32'(charSize) + 1))) | charData);
					fill_q <= fill_q + 3'h1;
				end
			end
		end
	end
endmodule

// ===== rtl/wfad_core.sv
// instruction field decode and effective address formation over axi4-lite
// Functional notes
// - words are 24 bits, bit 0 is the leftmost
// - bit 0 is the sign, negatives in two's complement
// - character words hold four six-bit characters
// - opcode from bits 2-8, address from bits 9-23
// - bit 0 set makes the address point at the real address
// - bit 1 set adds low 15 index bits to the address
// - bit 2 set suppresses indexing
// - next instruction pointer always holds the next instruction address
// - all memory traffic passes through the memory buffer register
// - index register is 24 bits, low bits used for indexing
// - extension register holds the low half in double precision
// - address is 15 bits, up to 32768 words
// - io buffer moves 6, 12, 18 or 24 bit characters
// - a second character buffer lets two transfers interlace; here the two buffers take turns on whole words of the one character input
// - parallel channel moves whole 24-bit words
// - two interrupt channels standard, more in groups of eight
// - instructions can enable and disable interrupts
// - lock-up mode stalls on io, interrupt mode overlaps; here ioStall rises for character input only, never for the parallel channel
// - basic add takes two machine cycles
// - indirect chains have no depth limit
// - io buffers assemble characters into words for memory
// - index is added before the indirect fetch
// - each indirect level adds one machine cycle
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module wfad_core #(
	parameter int IRQ_GROUPS = 0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// core memory port
	output logic memRead,
	output logic [wfad_pkg::ADDR_W-1:0] memAddr,
	input wire logic memAck,
	input wire logic [wfad_pkg::WORD_W-1:0] memRdata,
	// character and parallel io
	input wire logic ioCharValid,
	input wire logic [wfad_pkg::WORD_W-1:0] ioCharData,
	input wire logic ioParValid,
	input wire logic [wfad_pkg::WORD_W-1:0] ioParData,
	// decode results
	output logic busy,
	output logic ioStall,
	output logic irqEnable
);
	localparam int W = wfad_pkg::WORD_W;
	localparam int A = wfad_pkg::ADDR_W;
	localparam int NIRQ = wfad_pkg::BASE_IRQ + wfad_pkg::IRQ_GROUP * IRQ_GROUPS;

	typedef enum logic [1:0] {WFAD_IDLE, WFAD_FETCH, WFAD_DONE} wfad_state_t;

	wfad_state_t state_q;
	logic [W-1:0] instr_q, index_q, mainReg_q, extReg_q, memBuf_q, ioWord_q;
	logic [A-1:0] nextPtr_q, effAddr_q;
	logic [15:0] cycles_q;
	logic lockMode_q, start_q, secondBuf_q;
	logic [1:0] charSize_q;
	logic ackMeta_q, ackSync_q, charMeta_q, charSync_q, parMeta_q, parSync_q;
	logic [W-1:0] rdMeta_q, rdSync_q, chMeta_q, chSync_q, pwMeta_q, pwSync_q;
	logic asmValid;
	logic [wfad_pkg::NUM_IO_BUF-1:0] asmValidV;
	logic [W-1:0] asmWordV [wfad_pkg::NUM_IO_BUF];
	logic bufSel_q;
	logic [W-1:0] asmWord;
	logic [A-1:0] indexed;
	logic indirect;
	logic awHeld_q, wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;

	//////////////////////////////////////////////////////////////////////////
	// field decode of a word: bit n lives at index 23-n
	function automatic logic [A-1:0] addrOf(input logic [W-1:0] w);
		addrOf = w[A-1:0];
	endfunction
	function automatic logic [A-1:0] addIdx(input logic [W-1:0] w, input logic [W-1:0] x);
		logic doIdx;
		doIdx = w[wfad_pkg::BIT_IDX] & ~w[wfad_pkg::BIT_NOIDX];
		addIdx = doIdx ? A'(addrOf(w) + x[A-1:0]) : addrOf(w);
	endfunction

	assign indexed = addIdx(memBuf_q, index_q); // index before indirection
	assign indirect = memBuf_q[wfad_pkg::BIT_IND];

	//////////////////////////////////////////////////////////////////////////
	// pin inputs pass two flip-flops before use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ackMeta_q <= 1'b0;
			ackSync_q <= 1'b0;
			charMeta_q <= 1'b0;
			charSync_q <= 1'b0;
			parMeta_q <= 1'b0;
			parSync_q <= 1'b0;
			rdMeta_q <= '0;
			rdSync_q <= '0;
			chMeta_q <= '0;
			chSync_q <= '0;
			pwMeta_q <= '0;
			pwSync_q <= '0;
		end else begin
			ackMeta_q <= memAck;
			ackSync_q <= ackMeta_q;
			charMeta_q <= ioCharValid;
			charSync_q <= charMeta_q;
			parMeta_q <= ioParValid;
			parSync_q <= parMeta_q;
			rdMeta_q <= memRdata;
			rdSync_q <= rdMeta_q;
			chMeta_q <= ioCharData;
			chSync_q <= chMeta_q;
			pwMeta_q <= ioParData;
			pwSync_q <= pwMeta_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// address chain: one machine cycle per step, no depth limit
	// memory ack is a level held until memRead drops; the fsm waits for it to fall
	logic ackSeen_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= WFAD_IDLE;
			memBuf_q <= '0;
			effAddr_q <= '0;
			cycles_q <= '0;
			memRead <= 1'b0;
			memAddr <= '0;
			busy <= 1'b0;
			ackSeen_q <= 1'b0;
			nextPtr_q <= '0;
		end else begin
			case (state_q)
				WFAD_IDLE: begin
					if (start_q) begin
						memBuf_q <= instr_q;
						cycles_q <= 16'(wfad_pkg::ADD_CYCLES);
						busy <= 1'b1;
						state_q <= WFAD_DONE;
						if (instr_q[wfad_pkg::BIT_IND]) begin
							state_q <= WFAD_FETCH;
						end
						memAddr <= addIdx(instr_q, index_q);
						memRead <= instr_q[wfad_pkg::BIT_IND];
						ackSeen_q <= 1'b0;
					end
				end
				WFAD_FETCH: begin
					if (ackSync_q && !ackSeen_q) begin
						memBuf_q <= rdSync_q; // pointer word lands here
						cycles_q <= cycles_q + 16'h0001;
						memRead <= 1'b0;
						ackSeen_q <= 1'b1;
					end else if (ackSeen_q && !ackSync_q) begin
						ackSeen_q <= 1'b0;
						if (indirect) begin
							memAddr <= indexed;
							memRead <= 1'b1;
						end else begin
							state_q <= WFAD_DONE;
						end
					end
				end
				default: begin
					effAddr_q <= (memBuf_q == instr_q) ? addIdx(instr_q, index_q) : indexed;
					busy <= 1'b0;
					nextPtr_q <= A'(nextPtr_q + {{(A-1){1'b0}}, 1'b1});
					state_q <= WFAD_IDLE;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// two character buffers in one loop; with the second on, full words alternate
	// between them so one can hand its word off while the other fills
	for (genvar gi = 0; gi < int'(wfad_pkg::NUM_IO_BUF); gi++) begin : g_buf
		wfad_char_asm #(.W(W), .C(wfad_pkg::CHAR_W)) u_asm (
			.clk(clk),
			.rst_b(rst_b),
			.charValid(charSync_q && (bufSel_q == 1'(gi))),
			.charData(chSync_q),
			.charSize(charSize_q),
			.wordValid(asmValidV[gi]),
			.wordData(asmWordV[gi])
		);
	end
	assign asmValid = |asmValidV;
	assign asmWord = asmValidV[1] ? asmWordV[1] : asmWordV[0];

	// steering flips a cycle after a word leaves, so with the second buffer on
	// characters must stand at least two clocks apart
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bufSel_q <= 1'b0;
		end else if (!secondBuf_q) begin
			bufSel_q <= 1'b0;
		end else if (asmValid) begin
			bufSel_q <= ~bufSel_q;
		end
	end

	// io word landing and lock-up stall
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ioWord_q <= '0;
			ioStall <= 1'b0;
		end else begin
			if (parSync_q) begin
				ioWord_q <= pwSync_q;
			end else if (asmValid) begin
				ioWord_q <= asmWord;
			end
			ioStall <= lockMode_q & charSync_q & ~asmValid;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data taken in either order
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awready <= 1'b1;
			wready <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			bvalid <= 1'b0;
			bresp <= wfad_pkg::RESP_OK;
			instr_q <= '0;
			index_q <= '0;
			mainReg_q <= '0;
			extReg_q <= '0;
			lockMode_q <= 1'b1;
			irqEnable <= 1'b0;
			charSize_q <= wfad_pkg::CSZ_6;
			secondBuf_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (awvalid && awready) begin
				awAddr_q <= awaddr;
				awHeld_q <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_q <= wdata;
				wStrb_q <= wstrb;
				wHeld_q <= 1'b1;
				wready <= 1'b0;
			end
			if (awHeld_q && wHeld_q && !bvalid) begin
				bvalid <= 1'b1;
				bresp <= wfad_pkg::RESP_OK;
				if (!(&wStrb_q[2:0])) begin
					bresp <= wfad_pkg::RESP_ERR; // partial words refused
				end else if (awAddr_q == wfad_pkg::A_CTRL) begin
					lockMode_q <= wData_q[0];
					irqEnable <= wData_q[1];
					charSize_q <= wData_q[3:2];
					secondBuf_q <= wData_q[4];
				end else if (awAddr_q == wfad_pkg::A_INSTR) begin
					instr_q <= wData_q[W-1:0];
					start_q <= ~busy;
				end else if (awAddr_q == wfad_pkg::A_INDEX) begin
					index_q <= wData_q[W-1:0];
				end else if (awAddr_q == wfad_pkg::A_MAINREG) begin
					mainReg_q <= wData_q[W-1:0];
				end else if (awAddr_q == wfad_pkg::A_EXTREG) begin
					extReg_q <= wData_q[W-1:0];
				end else begin
					bresp <= wfad_pkg::RESP_ERR;
				end
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// axi4-lite read; 24-bit words sign-free in low bits, upper bits zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= wfad_pkg::RESP_OK;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= wfad_pkg::RESP_OK;
				if (araddr == wfad_pkg::A_CTRL) begin
					rdata <= {27'h0, secondBuf_q, charSize_q, irqEnable, lockMode_q};
				end else if (araddr == wfad_pkg::A_STATUS) begin
					rdata <= {16'(NIRQ), 6'h0, mainReg_q[wfad_pkg::SIGN_BIT], ioStall, busy,
						instr_q[wfad_pkg::OP_HI:wfad_pkg::OP_LO]};
				end else if (araddr == wfad_pkg::A_INSTR) begin
					rdata <= {8'h0, instr_q};
				end else if (araddr == wfad_pkg::A_INDEX) begin
					rdata <= {8'h0, index_q};
				end else if (araddr == wfad_pkg::A_NEXTPTR) begin
					rdata <= {17'h0, nextPtr_q};
				end else if (araddr == wfad_pkg::A_EFFADDR) begin
					rdata <= {17'h0, effAddr_q};
				end else if (araddr == wfad_pkg::A_MAINREG) begin
					rdata <= {8'h0, mainReg_q};
				end else if (araddr == wfad_pkg::A_EXTREG) begin
					rdata <= {8'h0, extReg_q};
				end else if (araddr == wfad_pkg::A_MEMBUF) begin
					rdata <= {8'h0, memBuf_q};
				end else if (araddr == wfad_pkg::A_CYCLES) begin
					rdata <= {16'h0, cycles_q};
				end else if (araddr == wfad_pkg::A_IOWORD) begin
					rdata <= {8'h0, ioWord_q};
				end else if (araddr == wfad_pkg::A_IOCFG) begin
					rdata <= {29'h0, wfad_pkg::NUM_IO_BUF};
				end else begin
					rdata <= '0;
					rresp <= wfad_pkg::RESP_ERR;
				end
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule

// ===== sim/wfad_assertions.sv
// port-level checker for the decode block
`timescale 1ns/1ps
module wfad_assertions #(
	parameter int IRQ_GROUPS = 0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// memory and status
	input wire logic memRead,
	input wire logic [wfad_pkg::ADDR_W-1:0] memAddr,
	input wire logic memAck,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	// both write halves taken at one edge, as the bench offers them
	sequence s_wTaken; awvalid && awready && wvalid && wready; endsequence
	sequence s_arTaken; arvalid && arready; endsequence
	property p_bAnswer; s_wTaken |-> ##[1:2] bvalid; endproperty
	property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	property p_rAnswer; s_arTaken |=> rvalid; endproperty
	property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	property p_addrHold; memRead [*2] |-> $stable(memAddr); endproperty
	property p_ackDrop; $rose(memAck) |-> ##[2:4] !memRead; endproperty
	property p_fetchBusy; memRead |-> busy; endproperty
	// chains here are short, so a long busy spell means a stuck sequencer
	property p_formBound; $rose(busy) |-> ##[2:300] !busy; endproperty
	a_bAnswer: assert property (p_bAnswer)
		else $error("write response missing");
	a_bHold: assert property (p_bHold)
		else $error("write response dropped");
	a_rAnswer: assert property (p_rAnswer)
		else $error("read data late");
	a_rHold: assert property (p_rHold)
		else $error("read data dropped");
	a_addrHold: assert property (p_addrHold)
		else $error("fetch address moved");
	a_ackDrop: assert property (p_ackDrop)
		else $error("fetch not withdrawn");
	a_fetchBusy: assert property (p_fetchBusy)
		else $error("fetch while idle");
	a_formBound: assert property (p_formBound)
		else $error("address formation hung");
endmodule
bind wfad_core wfad_assertions #(.IRQ_GROUPS(IRQ_GROUPS)) u_chk (.clk, .rst_b, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
	.memRead, .memAddr, .memAck, .busy);

// ===== sim/wfad_mem_model.sv
// behavioural core memory answering indirect fetches
`timescale 1ns/1ps
module wfad_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// fetch port
	input wire logic memRead,
	input wire logic [wfad_pkg::ADDR_W-1:0] memAddr,
	output logic memAck,
	output logic [wfad_pkg::WORD_W-1:0] memRdata
);
	int waitCnt_q;
	////////////////////////////////////////
	// chains climb by 0x2000 and stop once the top bits are 11
	function automatic logic [23:0] word(input logic [14:0] a);
		return {a[14:13] != 2'h3, 8'h00, a + 15'h2000};
	endfunction
	// random stall before ack; data toggles when not held so stale values never match
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			memAck <= 1'b0;
			memRdata <= 24'h5a5a5a;
			waitCnt_q <= 0;
		end else if (memAck) begin
			if (!memRead) begin
				memAck <= 1'b0;
				memRdata <= ~memRdata;
				waitCnt_q <= $urandom_range(3, 0);
			end
		end else if (memRead && waitCnt_q == 0) begin
			memAck <= 1'b1;
			memRdata <= word(memAddr);
		end else begin
			memRdata <= ~memRdata;
			if (waitCnt_q > 0) waitCnt_q <= waitCnt_q - 1;
		end
	end
endmodule

// ===== sim/wfad_bench.sv
// self-checking bench for the decode block
`timescale 1ns/1ps
module wfad_bench;
	logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic memRead, memAck, ioCharValid, ioParValid, busy, ioStall, irqEnable;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, n0;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [14:0] memAddr;
	logic [23:0] memRdata, ioCharData, ioParData, ins, idx, w, last;
	logic [23:0] tbl[4] = '{24'h407fff, 24'h607fff, 24'hc00123, 24'h800000};
	int errorCnt = 0;
	int cmpCount = 0;
	int lv;
	////////////////////////////////////////
	wfad_core #(.IRQ_GROUPS(1)) u_dut (.clk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .memRead, .memAddr, .memAck, .memRdata, .ioCharValid, .ioCharData,
		.ioParValid, .ioParData, .busy, .ioStall, .irqEnable);
	wfad_mem_model u_mem (.clk, .rst_b, .memRead, .memAddr, .memAck, .memRdata);
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			errorCnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic giveVerdict;
		$display("compares %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// a spent wait counts as a mismatch and ends the run
	task automatic tmo(input int n);
		if (n > 200) begin
			errorCnt++;
			giveVerdict();
		end
	endtask
	// one write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n <= 200; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rs = bresp;
		bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n <= 200; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
		tmo(n);
	endtask
	task automatic run(input logic [23:0] i);
		int n;
		wr(wfad_pkg::A_INSTR, {8'h00, i});
		repeat (2) @(posedge clk);
		for (n = 0; n <= 200 && busy !== 1'b0; n++) @(posedge clk);
		tmo(n);
	endtask
	////////////////////////////////////////
	function automatic logic [23:0] mw(input logic [14:0] a);
		return {a[14:13] != 2'h3, 8'h00, a + 15'h2000};
	endfunction
	// index first, then follow pointers one level at a time
	function automatic logic [14:0] ea(input logic [23:0] i, output int l, output logic [23:0] lw);
		logic [14:0] a;
		a = i[14:0];
		l = 0;
		if (i[22] && !i[21]) a = a + idx[14:0];
		while (i[23]) begin
			i = mw(a);
			lw = i;
			a = i[14:0];
			if (i[22] && !i[21]) a = a + idx[14:0];
			l++;
		end
		return a;
	endfunction
	////////////////////////////////////////
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, ioCharValid, ioParValid} = '0;
		{awaddr, araddr, wdata, wstrb, ioCharData, ioParData} = '0;
		rst_b = 1'b0;
		void'($urandom(32'h2c93));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd32(wfad_pkg::A_CTRL, rd);
		chk("ctrl", rd, 32'h1);
		rd32(wfad_pkg::A_IOCFG, rd);
		chk("iocfg", rd, 32'h2);
		rd32(wfad_pkg::A_STATUS, rd);
		chk("irqCount", 32'(rd[31:16]), 32'ha);
		for (int k = 0; k < 2; k++) begin
			w = {k[0], 23'($urandom)};
			wr(wfad_pkg::A_MAINREG, {8'h00, w});
			wr(wfad_pkg::A_EXTREG, {8'h00, ~w});
			rd32(wfad_pkg::A_STATUS, rd);
			chk("sign", 32'(rd[9]), 32'(w[23]));
			rd32(wfad_pkg::A_EXTREG, rd);
			chk("ext", rd, {8'h00, ~w});
			rd32(wfad_pkg::A_MAINREG, rd);
			chk("main", rd, {8'h00, w});
		end
		$display("test registers done");
		idx = 24'hf87001;
		wr(wfad_pkg::A_INDEX, {8'h00, idx});
		wr(wfad_pkg::A_INDEX, 32'h0, 4'h1);
		chk("strbResp", 32'(rs), 32'(wfad_pkg::RESP_ERR));
		wr(8'h30, 32'h0);
		chk("mapResp", 32'(rs), 32'(wfad_pkg::RESP_ERR));
		rd32(8'h3c, rd);
		chk("rdResp", 32'(rs), 32'(wfad_pkg::RESP_ERR));
		rd32(wfad_pkg::A_INDEX, rd);
		chk("index", rd, {8'h00, idx});
		$display("test refusals done");
		rd32(wfad_pkg::A_NEXTPTR, n0);
		for (int k = 0; k < 16; k++) begin
			ins = k < 4 ? tbl[k] : 24'($urandom);
			run(ins);
			rd32(wfad_pkg::A_EFFADDR, rd);
			chk("effAddr", rd, 32'(ea(ins, lv, last)));
			rd32(wfad_pkg::A_STATUS, rd);
			chk("opcode", 32'(rd[6:0]), 32'(ins[21:15]));
			rd32(wfad_pkg::A_CYCLES, rd);
			chk("cycles", rd, 2 + lv);
			if (lv > 0) rd32(wfad_pkg::A_MEMBUF, rd);
			if (lv > 0) chk("memBuf", rd, {8'h00, last});
			rd32(wfad_pkg::A_NEXTPTR, rd);
			chk("nextPtr", rd, (n0 + k + 1) & 32'h7fff);
		end
		$display("test decode done");
		for (int k = 0; k < 2; k++) begin
			wr(wfad_pkg::A_CTRL, {30'h0, k[0], 1'b1});
			chk("irqEn", 32'(irqEnable), 32'(k[0]));
		end
		// one-clock strobes: the buffer counts every cycle that valid stands;
		// two words per size, the second buffer on for odd sizes
		for (int k = 0; k < 4; k++) begin
			wr(wfad_pkg::A_CTRL, {27'h0, k[0], k[1:0], 2'h1});
			rd32(wfad_pkg::A_CTRL, rd);
			chk("ctrlRb", rd, {27'h0, k[0], k[1:0], 2'h1});
			w = '0;
			for (int j = 0; j < (k == 2 ? 2 : 48 / (6 * (k + 1))); j++) begin
				ins = 24'($urandom & ((32'h1 << (6 * (k + 1))) - 1));
				w = (k == 2) ? ins : 24'((w << (6 * (k + 1))) | ins);
				ioCharData <= ins;
				ioCharValid <= 1'b1;
				@(posedge clk);
				ioCharValid <= 1'b0;
				repeat (3) @(posedge clk);
				chk("ioStall", 32'(ioStall), 32'h1);
			end
			rd32(wfad_pkg::A_IOWORD, rd);
			chk("charWord", rd, {8'h00, w});
		end
		w = 24'($urandom);
		ioParData <= w;
		ioParValid <= 1'b1;
		repeat (4) @(posedge clk);
		ioParValid <= 1'b0;
		repeat (3) @(posedge clk);
		rd32(wfad_pkg::A_IOWORD, rd);
		chk("parWord", rd, {8'h00, w});
		chk("ioIdle", 32'(ioStall), 32'h0);
		$display("test io done");
		giveVerdict();
	end
endmodule
